// ### design/tbz_top.sv
// Top: time base tick interrupt and buzzer divider with AXI4-Lite slave
//
// What this block does
// - Rate code picks fc or fs tap
// - Tick on each falling edge from one cycle after enabling
// - Enabling never resets the divider chain
// - Tick enable bit 3, rate bits 2:0
// - Buzzer enable sits at bit 7
// - Buzzer pin gives square wave from tap
// - Freq code picks fc or fs tap
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
module tbz_top
    import tbz_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        fs_clk_pin,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             tick_interrupt,
    output logic             irq,
    output logic             buzzer_out_pin
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [2:0]         fs_sync;
        logic [7:0]         ctrl;
        logic [1:0]         mode;
        logic [TBZ_NEV-1:0] status;
        logic [TBZ_NEV-1:0] irq_en;
        logic               tap_prev;
        logic               armed;
        logic               aw_got;
        logic [7:0]         aw_addr;
        logic               w_got;
        logic [31:0]        w_data;
        logic [3:0]         w_strb;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               rvalid;
        logic [31:0]        rdata;
        logic [1:0]         rresp;
        logic               tick_pulse;
        logic               irq;
        logic               buz;
    } tbz_state_t;

    tbz_state_t s_q;
    tbz_state_t s_d;

    tbz_tap_if taps ();

    logic fs_tick;
    logic slow_src;

    // Rising edge of synchronised low clock pin is the fs count enable
    assign fs_tick  = s_q.fs_sync[1] & ~s_q.fs_sync[2];
    assign slow_src = s_q.mode[TBZ_SLOWTAP_BIT] | s_q.mode[TBZ_SLOWSYS_BIT];

    // Tap selection from control fields
    assign taps.slow = slow_src;
    assign taps.rate = s_q.ctrl[TBZ_RATE_LSB +: TBZ_RATE_W];
    assign taps.freq = s_q.ctrl[TBZ_FREQ_LSB +: TBZ_FREQ_W];

    tbz_div_chain u_chain (
        .clk     (clk),
        .sys_rst (sys_rst),
        .fs_tick (fs_tick),
        .taps    (taps)
    );

    // Register decode, shared by read and write paths
    function automatic logic tbz_mapped(input logic [7:0] a);
        return (a == TBZ_OFS_CTRL) || (a == TBZ_OFS_STATUS) ||
               (a == TBZ_OFS_CLEAR) || (a == TBZ_OFS_IRQ_EN) ||
               (a == TBZ_OFS_MODE);
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic       wr_go;
        logic       ev_tick;
        logic       ev_bad;
        logic [7:0] wb;
        logic [TBZ_NEV-1:0] clr;
        wr_go   = 1'b0;
        ev_tick = 1'b0;
        ev_bad  = 1'b0;
        wb      = 8'h00;
        clr     = '0;
        s_d     = s_q;

        // Two flops before anything looks at the pin
        s_d.fs_sync = {s_q.fs_sync[1:0], fs_clk_pin};

        // Tick on falling tap edge; armed one cycle after the enable bit is set
        s_d.tap_prev = taps.tick_tap;
        if (!s_q.ctrl[TBZ_TICK_EN_BIT]) begin
            s_d.armed = 1'b0;
        end else begin
            s_d.armed = 1'b1;
        end
        // Chain keeps running, so first tick can come early
        ev_tick = s_q.ctrl[TBZ_TICK_EN_BIT] && s_q.armed &&
                  s_q.tap_prev && !taps.tick_tap;
        s_d.tick_pulse = ev_tick;

        // Buzzer pin follows its tap, rests low when disabled
        s_d.buz = s_q.ctrl[TBZ_BUZ_EN_BIT] & taps.buz_tap;

        // Write address and data captured in either order
        if (s_axi_awvalid && !s_q.aw_got) begin
            s_d.aw_got  = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_got) begin
            s_d.w_got  = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        wr_go = s_q.aw_got && s_q.w_got && !s_q.bvalid;
        wb    = s_q.w_strb[0] ? s_q.w_data[7:0] : 8'h00;
        if (wr_go) begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = tbz_mapped(s_q.aw_addr) ? 2'h0 : 2'h2;
            if (s_q.w_strb[0]) begin
                case (s_q.aw_addr)
                    TBZ_OFS_CTRL: begin
                        // Full byte taken; field stability is software's job
                        s_d.ctrl = wb;
                        // Slow clock only supports the two lowest rates
                        ev_bad = s_q.mode[TBZ_SLOWSYS_BIT] &&
                                 (wb[TBZ_RATE_LSB +: TBZ_RATE_W] > 3'h1);
                    end
                    TBZ_OFS_CLEAR: clr = wb[TBZ_NEV-1:0];
                    TBZ_OFS_IRQ_EN: s_d.irq_en = wb[TBZ_NEV-1:0];
                    TBZ_OFS_MODE: s_d.mode = wb[1:0];
                    default: ;
                endcase
            end
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        // Sticky status: a set in the clearing cycle wins
        s_d.status = (s_q.status & ~clr) | {ev_bad, ev_tick};
        s_d.irq    = |(s_d.status & s_q.irq_en);

        // Read path, one read at a time
        if (s_axi_arvalid && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = tbz_mapped(s_axi_araddr) ? 2'h0 : 2'h2;
            case (s_axi_araddr)
                TBZ_OFS_CTRL:   s_d.rdata = {24'h0, s_q.ctrl};
                TBZ_OFS_STATUS: s_d.rdata = {30'h0, s_q.status};
                TBZ_OFS_IRQ_EN: s_d.rdata = {30'h0, s_q.irq_en};
                TBZ_OFS_MODE:   s_d.rdata = {30'h0, s_q.mode};
                default:        s_d.rdata = 32'h0;
            endcase
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q        <= '0;
            s_q.ctrl   <= TBZ_CTRL_RST;
            s_q.mode   <= TBZ_MODE_RST;
            s_q.status <= TBZ_EV_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops
    assign s_axi_awready  = ~s_q.aw_got;
    assign s_axi_wready   = ~s_q.w_got;
    assign s_axi_bvalid   = s_q.bvalid;
    assign s_axi_bresp    = s_q.bresp;
    assign s_axi_arready  = ~s_q.rvalid;
    assign s_axi_rvalid   = s_q.rvalid;
    assign s_axi_rdata    = s_q.rdata;
    assign s_axi_rresp    = s_q.rresp;
    assign tick_interrupt = s_q.tick_pulse;
    assign irq            = s_q.irq;
    assign buzzer_out_pin = s_q.buz;

endmodule

// ### design/tbz_pkg.sv
// Package: register map, field layout and tap tables of the time base block
package tbz_pkg;

    // ************************************************************
    // Register map (byte addresses, one aligned word each)
    // ************************************************************
    localparam logic [7:0] TBZ_OFS_CTRL    = 8'h00;
    localparam logic [7:0] TBZ_OFS_STATUS  = 8'h04;
    localparam logic [7:0] TBZ_OFS_CLEAR   = 8'h08;
    localparam logic [7:0] TBZ_OFS_IRQ_EN  = 8'h0C;
    localparam logic [7:0] TBZ_OFS_MODE    = 8'h10;

    // ************************************************************
    // Control register fields and reset values
    // ************************************************************
    localparam int         TBZ_RATE_LSB    = 0;
    localparam int         TBZ_RATE_W      = 3;
    localparam int         TBZ_TICK_EN_BIT = 3;
    localparam int         TBZ_FREQ_LSB    = 5;
    localparam int         TBZ_FREQ_W      = 2;
    localparam int         TBZ_BUZ_EN_BIT  = 7;
    localparam logic [7:0] TBZ_CTRL_RST    = 8'h00;
    // Mode register: bit 0 slow tap select, bit 1 slow clock running
    localparam int         TBZ_SLOWTAP_BIT = 0;
    localparam int         TBZ_SLOWSYS_BIT = 1;
    localparam logic [1:0] TBZ_MODE_RST    = 2'h0;
    // Status bits: 0 tick event, 1 slow-mode illegal rate written
    localparam int         TBZ_NEV         = 2;
    localparam logic [1:0] TBZ_EV_RST      = 2'h0;

    // ************************************************************
    // Divider chain
    // ************************************************************
    localparam int         TBZ_FC_W        = 24;
    localparam int         TBZ_FS_W        = 16;

    // Tick tap bit index (tap of 2^n toggles at bit n-1)
    function automatic int tbz_rate_tap(input logic [2:0] code,
                                        input logic       slow);
        int fc_t [8];
        int fs_t [8];
        fc_t = '{22, 20, 15, 13, 12, 11, 10, 8};
        fs_t = '{14, 12, 7, 5, 4, 3, 2, 0};
        return slow ? fs_t[code] : fc_t[code];
    endfunction

    // Buzzer tap bit index
    function automatic int tbz_freq_tap(input logic [1:0] code,
                                        input logic       slow);
        int fc_t [4];
        int fs_t [4];
        fc_t = '{12, 11, 10, 9};
        fs_t = '{4, 3, 2, 1};
        return slow ? fs_t[code] : fc_t[code];
    endfunction

endpackage

// ### design/tbz_tap_if.sv
// Interface: divider tap selection and tap levels between chain and top
interface tbz_tap_if;
    logic       slow;
    logic [2:0] rate;
    logic [1:0] freq;
    logic       tick_tap;
    logic       buz_tap;

    modport chain (
        input  slow,
        input  rate,
        input  freq,
        output tick_tap,
        output buz_tap
    );
    modport ctrl (
        output slow,
        output rate,
        output freq,
        input  tick_tap,
        input  buz_tap
    );
endinterface

// ### design/tbz_div_chain.sv
// Free-running fc and fs divider chain with tap multiplexers
module tbz_div_chain
    import tbz_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   sys_rst,
    input  wire logic   fs_tick,
    tbz_tap_if.chain    taps
);

    typedef struct packed {
        logic [TBZ_FC_W-1:0] fc_cnt;
        logic [TBZ_FS_W-1:0] fs_cnt;
    } tbz_chain_t;

    tbz_chain_t s_q;
    tbz_chain_t s_d;

    // Chain never cleared by software, only by system reset
    always_comb begin
        s_d = s_q;
        s_d.fc_cnt = s_q.fc_cnt + 1'b1;
        if (fs_tick) begin
            s_d.fs_cnt = s_q.fs_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Tap select by rate or freq code and source
    always_comb begin
        if (taps.slow) begin
            taps.tick_tap = s_q.fs_cnt[tbz_rate_tap(taps.rate, 1'b1)];
            taps.buz_tap  = s_q.fs_cnt[tbz_freq_tap(taps.freq, 1'b1)];
        end else begin
            taps.tick_tap = s_q.fc_cnt[tbz_rate_tap(taps.rate, 1'b0)];
            taps.buz_tap  = s_q.fc_cnt[tbz_freq_tap(taps.freq, 1'b0)];
        end
    end

endmodule

// ### sim/tbz_properties.sv
// Checker: port-level timing properties of the time base block
module tbz_props (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        tick_interrupt,
    input wire logic        irq,
    input wire logic        buzzer_out_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    // ************************************************************
    // Properties, all in the clk domain
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Shortest legal tick period is 16 clocks, so 8 quiet ones is safe
    tick_single_a: assert property (tick_interrupt |=>
        !tick_interrupt[*8])
        else $error("tick request too wide or too close");
    reset_idle_a: assert property ($fell(sys_rst) |->
        !tick_interrupt && !irq && !buzzer_out_pin)
        else $error("outputs not idle after reset");
    aw_taken_a: assert property (s_axi_awvalid && s_axi_awready |=>
        !s_axi_awready)
        else $error("write address accepted twice");
    // Address slot frees on the response edge, so look one cycle back
    b_early_a: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready))
        else $error("write response without held address");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid)
        else $error("read data late");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while busy");
endmodule

bind tbz_top tbz_props u_props (.clk(clk), .sys_rst(sys_rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .tick_interrupt(tick_interrupt), .irq(irq),
    .buzzer_out_pin(buzzer_out_pin));

// ### sim/tbz_far_model.sv
// Model of interrupt controller and buzzer: measures tick gaps and tone
module tbz_far_model (
    input  wire logic clk,
    input  wire logic tick_interrupt,
    input  wire logic buzzer_out_pin,
    output int        gap,
    output int        seen,
    output int        hi,
    output int        falls
);
    timeunit 1ns;
    timeprecision 1ns;
    int since = 0;
    int run = 0;
    initial {gap, seen, hi, falls} = '0;

    // Gap between ticks and high width of the tone, in clocks
    always @(posedge clk) begin
        since <= tick_interrupt ? 1 : since + 1;
        if (tick_interrupt) begin
            gap <= since;
            seen <= seen + 1;
        end
        run <= buzzer_out_pin ? run + 1 : 0;
        if (!buzzer_out_pin && run != 0) begin
            hi <= run;
            falls <= falls + 1;
        end
    end
endmodule

// ### sim/time_base_and_buzzer_divider_bench.sv
// Self-checking bench of the time base and buzzer block
module time_base_and_buzzer_divider_bench import tbz_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, sys_rst = 1, fs = 0, awv = 0, wv = 0, br = 0;
    logic        arv = 0, rr = 0, awr, wr_r, bv, arr, rv, tick, irq, pin;
    logic [7:0]  awa = '0, ara = '0;
    logic [31:0] wd = '0, rd_d;
    logic [3:0]  ws = '0;
    logic [1:0]  bresp, rresp;
    logic [33:0] exp_q [$];
    int          err_total = 0, checks_done = 0, gap, seen, hi, falls;
    int          s, r, k, f;
    int          fc_e [8] = '{23, 21, 16, 14, 13, 12, 11, 9};
    int          fs_e [8] = '{15, 13, 8, 6, 5, 4, 3, 1};

    // Fast clock, and slow clock of exactly 8 clocks at an odd phase
    initial forever #10 clk = ~clk;
    initial begin
        #7;
        forever #80 fs = ~fs;
    end

    tbz_top u_dut (.clk(clk), .sys_rst(sys_rst), .fs_clk_pin(fs),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .tick_interrupt(tick),
        .irq(irq), .buzzer_out_pin(pin));
    tbz_far_model u_far (.clk(clk), .tick_interrupt(tick),
        .buzzer_out_pin(pin), .gap(gap), .seen(seen), .hi(hi), .falls(falls));

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        exp_q.push_back(a > TBZ_OFS_MODE ? 34'h2 : 34'h0);
        @(posedge clk);
        {awa, wd, ws} <= {a, d, 4'hF};
        {awv, wv, br} <= 3'b111;
        do begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wr_r) wv <= 0;
        end while (!bv);
        br <= 0;
    endtask

    // Read: expected word noted first, the monitor compares it
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        ara <= a;
        {arv, rr} <= 2'b11;
        do begin
            @(posedge clk);
            if (arr) arv <= 0;
        end while (!rv);
        rr <= 0;
    endtask

    always @(posedge clk) if (rv && rr) chk({rresp, rd_d}, exp_q.pop_front());
    // Write response taken off the same queue, writes and reads never overlap
    always @(posedge clk) if (bv && br) chk({32'h0, bresp}, exp_q.pop_front());

    // Two complete events, so the last measure is a full period or a full high phase
    task automatic wait2(input bit buz);
        k = buz ? falls : seen;
        wait ((buz ? falls : seen) >= k + 2);
        @(posedge clk);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Hang guard at 100k clocks, well beyond the expected run of under 50k clocks
    initial begin
        #2_000_000;
        err_total++;
        $display("Error %0t: watchdog expired", $time);
        final_report();
    end

    initial begin
        s = $urandom(17);
        repeat (8) @(posedge clk);
        sys_rst <= 0;
        rd(TBZ_OFS_CTRL, 34'h0);
        rd(TBZ_OFS_STATUS, 34'h0);
        rd(8'h14, {2'h2, 32'h0});
        wr(8'h14, 32'hFF);
        $display("test reset done");
        // Fast codes in turn from a random starting code; rate changed by the same write that sets the enable bit
        s = $urandom % 4;
        for (int i = 0; i < 4; i++) begin
            r = 4 + (s + i) % 4;
            wr(TBZ_OFS_CTRL, 32'h8 | r);
            wait2(0);
            chk(gap, 1 << fc_e[r]);
            wr(TBZ_OFS_CTRL, r);
        end
        repeat (4) @(posedge clk);
        k = seen;
        repeat (600) @(posedge clk);
        chk(seen, k);
        $display("test fast ticks done");
        // Sticky status, enable, mask and clear
        rd(TBZ_OFS_STATUS, 34'h1);
        wr(TBZ_OFS_IRQ_EN, 32'h1);
        repeat (3) @(posedge clk);
        chk(irq, 1);
        wr(TBZ_OFS_IRQ_EN, 32'h0);
        repeat (3) @(posedge clk);
        chk(irq, 0);
        wr(TBZ_OFS_IRQ_EN, 32'h1);
        wr(TBZ_OFS_CLEAR, 32'h1);
        rd(TBZ_OFS_STATUS, 34'h0);
        chk(irq, 0);
        $display("test interrupt done");
        // Slow tap select; all codes legal as fs only feeds the taps
        wr(TBZ_OFS_MODE, 32'h1);
        for (r = 6; r < 8; r++) begin
            wr(TBZ_OFS_CTRL, 32'h8 | r);
            wait2(0);
            chk(gap, 8 << fs_e[r]);
            wr(TBZ_OFS_CTRL, r);
        end
        wr(TBZ_OFS_CTRL, 32'hE0);
        wait2(1);
        chk(hi, 16);
        wr(TBZ_OFS_CTRL, 32'h60);
        // Slow system clock: a fast rate code is flagged, not blocked
        wr(TBZ_OFS_MODE, 32'h3);
        wr(TBZ_OFS_CTRL, 32'h62);
        rd(TBZ_OFS_CTRL, 34'h62);
        rd(TBZ_OFS_MODE, 34'h3);
        rd(TBZ_OFS_STATUS, 34'h3);
        wr(TBZ_OFS_CLEAR, 32'h3);
        rd(TBZ_OFS_STATUS, 34'h0);
        wr(TBZ_OFS_MODE, 32'h0);
        $display("test slow taps done");
        // Buzzer on the fast chain with a random frequency code
        f = $urandom % 4;
        wr(TBZ_OFS_CTRL, 32'h80 | (f << 5));
        wait2(1);
        chk(hi, 1 << (12 - f));
        wr(TBZ_OFS_CTRL, f << 5);
        repeat (3) @(posedge clk);
        chk(pin, 0);
        $display("test buzzer done");
        final_report();
    end
endmodule
